// File: design/lgfs_lane_gain_flip_state_regs.sv
`timescale 1ns/1ps
`include "lgfs_regs.svh"
// byte register bank behind the two-wire management port;
// the port engine hands over byte address, write strobe and data
module lgfs_lane_gain_flip_state_regs
    import lgfs_pkg::*;
#(
    parameter int LANES = 4
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // register access from the management port engine
    input  wire logic [4:0]       reg_addr,
    input  wire logic             reg_wr,
    input  wire logic [7:0]       reg_wdata,
    output logic      [7:0]       reg_rdata,
    // live lane state from the lane logic
    input  wire lgfs_lane_state_t lane_zero_power_code,
    input  wire lgfs_lane_state_t lane_one_power_code,
    // equalizer controls per lane, lane 0 first
    output logic      [11:0]      boost_lanes,
    output logic      [7:0]       flat_gain_lanes,
    // flip controls
    output logic                  aux_pair_swap,
    output logic                  main_lane_orientation_swap
);
    // only the four documented lanes are decoded
    initial begin
        if (LANES != 4) begin
            $error("lgfs: LANES must be 4");
        end
    end

    logic [7:0] gain_val [LANES];   // gain bytes per lane
    logic [7:0] flip_reg;           // flip control byte
    logic [7:0] rsvd_a;             // reserved byte a
    logic [7:0] rsvd_b;             // reserved byte b
    logic [7:0] rsvd_c;             // reserved byte c
    logic [7:0] state_byte;         // sampled lane state byte
    logic [7:0] next_rdata;         // read mux result
    wire  [4:0] gain_base = `LGFS_OFF_LANE0_GAIN;

    // per-lane gain bytes at consecutive offsets
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : gen_lane
            wire gain_hit = reg_wr &&
                (reg_addr == gain_base + 5'(g)); // R2 R10
            lgfs_gain_reg #(
                .RESET_VAL (`LGFS_GAIN_RESET)
            ) u_gain (
                .core_clk  (core_clk),
                .rst       (rst),
                .wr_en     (gain_hit),
                .wr_data   (reg_wdata),
                .value     (gain_val[g]),
                .boost     (boost_lanes[g*3 +: 3]),
                .flat_gain (flat_gain_lanes[g*2 +: 2])
            );
        end
    endgenerate

    // write decode for the other read/write bytes
    wire flip_hit = reg_wr && (reg_addr == `LGFS_OFF_FLIP);
    wire rsva_hit = reg_wr && (reg_addr == `LGFS_OFF_RSVD_A);
    wire rsvb_hit = reg_wr && (reg_addr == `LGFS_OFF_RSVD_B);
    wire rsvc_hit = reg_wr && (reg_addr == `LGFS_OFF_RSVD_C);

    // flip and reserved bytes, whole byte stored
    always_ff @(posedge core_clk) begin
        if (rst) begin
            flip_reg <= `LGFS_FLIP_RESET; // R3 R4
            rsvd_a   <= `LGFS_RSVD_A_RESET;
            rsvd_b   <= `LGFS_RSVD_B_RESET;
            rsvd_c   <= `LGFS_RSVD_C_RESET;
        end else begin
            if (flip_hit) begin
                flip_reg <= reg_wdata; // R12
            end
            if (rsva_hit) begin
                rsvd_a <= reg_wdata; // R12
            end
            if (rsvb_hit) begin
                rsvd_b <= reg_wdata; // R12
            end
            if (rsvc_hit) begin
                rsvd_c <= reg_wdata; // R12
            end
        end
    end

    // flip outputs straight from the stored byte
    assign aux_pair_swap = flip_reg[`LGFS_AUX_SWAP_BIT]; // R3
    assign main_lane_orientation_swap =
        flip_reg[`LGFS_MAIN_SWAP_BIT]; // R4

    // state byte: lane 0 in 7:5, lane 1 in 3:1, reserved zero
    wire [7:0] state_live = {lane_zero_power_code, 1'b0,
                             lane_one_power_code, 1'b0}; // R5 R6 R7
    // sampled each cycle; writes never reach it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_byte <= 8'h00;
        end else begin
            state_byte <= state_live; // R5 R8 R9 R12
        end
    end

    // read mux, unmapped and out-of-window bytes read zero
    always_comb begin
        case (reg_addr)
            `LGFS_OFF_BYTE_COUNT: next_rdata = `LGFS_SPACE_BYTES; // R11
            `LGFS_OFF_LANE0_GAIN: next_rdata = gain_val[0];
            `LGFS_OFF_LANE1_GAIN: next_rdata = gain_val[1];
            `LGFS_OFF_LANE2_GAIN: next_rdata = gain_val[2];
            `LGFS_OFF_LANE3_GAIN: next_rdata = gain_val[3];
            `LGFS_OFF_FLIP:       next_rdata = flip_reg;
            `LGFS_OFF_RSVD_A:     next_rdata = rsvd_a;
            `LGFS_OFF_RSVD_B:     next_rdata = rsvd_b;
            `LGFS_OFF_RSVD_C:     next_rdata = rsvd_c;
            `LGFS_OFF_STATE01:    next_rdata = state_byte; // R5
            default:              next_rdata = 8'h00;
        endcase
    end

    // registered read data, one cycle after address
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end
endmodule

// File: design/lgfs_regs.svh
// Notes on behaviour
// R1 - lane one boost 6:4, flat gain 3:2=10
// R2 - lanes two, three same layout, independent
// R3 - flip bit1 swaps aux sideband/diff pairs
// R4 - flip bit0 swaps all main lane orientation
// R5 - state byte read-only, codes 7:5, 3:1
// R6 - 000 powered off, 001 ramping up
// R7 - 010 brief unplug, 011 lengthy unplug
// R8 - 100 unplug live, 101 link saving
// R9 - 110 slumber, 111 fully on
// R10 - lane zero same gain layout, reset 10
// R11 - 32-byte space, byte-count register reports it
// R12 - reserved rw bits store; read-only ignore writes
// R13 - host preserves reserved bits on updates
`ifndef LGFS_REGS_SVH
`define LGFS_REGS_SVH

// register offsets
`define LGFS_OFF_BYTE_COUNT 5'h02
`define LGFS_OFF_LANE0_GAIN 5'h05
`define LGFS_OFF_LANE1_GAIN 5'h06
`define LGFS_OFF_LANE2_GAIN 5'h07
`define LGFS_OFF_LANE3_GAIN 5'h08
`define LGFS_OFF_FLIP       5'h09
`define LGFS_OFF_RSVD_A     5'h0A
`define LGFS_OFF_RSVD_B     5'h0B
`define LGFS_OFF_RSVD_C     5'h0C
`define LGFS_OFF_STATE01    5'h0D

// field positions
`define LGFS_BOOST_HI       6
`define LGFS_BOOST_LO       4
`define LGFS_FLAT_HI        3
`define LGFS_FLAT_LO        2
`define LGFS_AUX_SWAP_BIT   1
`define LGFS_MAIN_SWAP_BIT  0

// reset values
`define LGFS_GAIN_RESET     8'h08
`define LGFS_FLIP_RESET     8'h00
`define LGFS_RSVD_A_RESET   8'hFC
`define LGFS_RSVD_B_RESET   8'hFC
`define LGFS_RSVD_C_RESET   8'h31
`define LGFS_SPACE_BYTES    8'h20

// timing: unplug split between brief and lengthy codes
`define LGFS_UNPLUG_SPLIT_MS 328

`endif

// File: design/lgfs_pkg.sv
package lgfs_pkg;
    // lane operating-state codes
    typedef enum logic [2:0] {
        powered_off_code    = 3'h0, // R6
        ramp_up_code        = 3'h1, // R6
        unplug_brief_code   = 3'h2, // R7
        unplug_lengthy_code = 3'h3, // R7
        unplug_live_code    = 3'h4, // R8
        link_saving_code    = 3'h5, // R8
        slumber_code        = 3'h6, // R9
        fully_on_code       = 3'h7  // R9
    } lgfs_lane_state_t;
endpackage

// File: design/lgfs_gain_reg.sv
`timescale 1ns/1ps
`include "lgfs_regs.svh"
// one lane gain byte with decoded boost and flat gain
module lgfs_gain_reg
    import lgfs_pkg::*;
#(
    parameter logic [7:0] RESET_VAL = `LGFS_GAIN_RESET
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // write port
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    // contents
    output logic      [7:0] value,
    output logic      [2:0] boost,
    output logic      [1:0] flat_gain
);
    // full byte stored, reserved bits kept as written
    always_ff @(posedge core_clk) begin
        if (rst) begin
            value <= RESET_VAL; // R1
        end else if (wr_en) begin
            value <= wr_data; // R12
        end
    end

    // field extraction
    assign boost     = value[`LGFS_BOOST_HI:`LGFS_BOOST_LO]; // R1
    assign flat_gain = value[`LGFS_FLAT_HI:`LGFS_FLAT_LO]; // R1
endmodule

// File: verif/lgfs_monitor.sv
`timescale 1ns/1ps
// watches the register bank ports
module lgfs_chk
    import lgfs_pkg::*;
(
    // clock, reset and register access
    input wire logic             core_clk, rst, reg_wr,
    input wire logic [4:0]       reg_addr,
    input wire logic [7:0]       reg_wdata, reg_rdata, flat_gain_lanes,
    // lane codes and controls
    input wire lgfs_lane_state_t lane_zero_power_code, lane_one_power_code,
    input wire logic [11:0]      boost_lanes,
    input wire logic             aux_pair_swap, main_lane_orientation_swap
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // writes reach the controls one cycle later
    lane0_gain_a: assert property (reg_wr && reg_addr == 5'h05 |=>
        {boost_lanes[2:0], flat_gain_lanes[1:0]} == $past(reg_wdata[6:2]))
        else $error("lane 0 gain wrong");
    lane1_gain_a: assert property (reg_wr && reg_addr == 5'h06 |=>
        {boost_lanes[5:3], flat_gain_lanes[3:2]} == $past(reg_wdata[6:2]))
        else $error("lane 1 gain wrong");
    lane3_gain_a: assert property (reg_wr && reg_addr == 5'h08 |=>
        {boost_lanes[11:9], flat_gain_lanes[7:6]} == $past(reg_wdata[6:2]))
        else $error("lane 3 gain wrong");
    flip_ctl_a: assert property (reg_wr && reg_addr == 5'h09 |=>
        {aux_pair_swap, main_lane_orientation_swap} == $past(reg_wdata[1:0]))
        else $error("flip wrong");
    // controls move only on a write
    ctl_hold_a: assert property (!reg_wr |=> $stable(boost_lanes) &&
        $stable(flat_gain_lanes) && $stable(aux_pair_swap) &&
        $stable(main_lane_orientation_swap))
        else $error("control moved");
    byte_count_a: assert property (reg_addr == 5'h02 |=>
        reg_rdata == 8'h20) else $error("byte count wrong");
    // state byte lags the live codes by two edges
    state_read_a: assert property (reg_addr == 5'h0D && !$past(rst) |=>
        reg_rdata == {$past(lane_zero_power_code, 2), 1'b0,
        $past(lane_one_power_code, 2), 1'b0}) else $error("state wrong");
    rsvd_back_a: assert property (reg_wr && reg_addr == 5'h0A ##1
        reg_addr == 5'h0A |=> reg_rdata == $past(reg_wdata, 2))
        else $error("reserved readback");
    cover property (reg_wr && reg_addr == 5'h06);
    cover property (reg_wr && reg_addr == 5'h09 && reg_wdata[1]);
    cover property (reg_addr == 5'h0D ##1 reg_addr == 5'h0D);
endmodule
bind lgfs_lane_gain_flip_state_regs lgfs_chk lgfs_chk_i (.*);

// File: verif/lgfs_host.sv
`timescale 1ns/1ps
// management port engine model: single byte writes and reads
module lgfs_host (
    // clock and register access
    input wire logic       core_clk,
    output logic     [4:0] reg_addr,
    output logic           reg_wr,
    output logic     [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    // idle on an unmapped byte, no strobe
    initial begin
        reg_addr = 5'h1F;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end
    // one byte write, strobe for one edge, data scrambled after
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
        #1;
    endtask
    // one byte read, data two edges after the address
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        repeat (2) @(posedge core_clk);
        #1 d = reg_rdata;
    endtask
endmodule

// File: verif/tb.sv
`timescale 1ns/1ps
// bench: reset bytes, gain, flip, read-only and state codes
module tb;
    import lgfs_pkg::*;
    logic             core_clk, rst, reg_wr, aux_pair_swap;
    logic             main_lane_orientation_swap;
    logic [4:0]       reg_addr;
    logic [7:0]       reg_wdata, reg_rdata, flat_gain_lanes, v;
    logic [11:0]      boost_lanes;
    lgfs_lane_state_t lane_zero_power_code, lane_one_power_code;
    int               n_errors = 0;
    int               num_checks = 0;
    logic [7:0]       rst_val [8] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h00,
                                      8'hFC, 8'hFC, 8'h31};
    lgfs_lane_gain_flip_state_regs lgfs_lane_gain_flip_state_regs_i (.*);
    lgfs_host lgfs_host_i (.*);
    // compare and count
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // read a byte and compare
    task automatic rc(input logic [4:0] a, input logic [7:0] e);
        lgfs_host_i.rd(a, v);
        chk({4'h0, v}, {4'h0, e});
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // 40 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // hang guard
    initial begin
        #50000;
        n_errors++;
        complete_run();
    end
    initial begin
        rst = 1'b1;
        lane_zero_power_code = powered_off_code;
        lane_one_power_code = fully_on_code;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        // power-up bytes and controls
        for (int i = 0; i < 8; i++) begin
            rc(5'h05 + 5'(i), rst_val[i]);
        end
        chk({flat_gain_lanes, aux_pair_swap, main_lane_orientation_swap},
            12'h2A8);
        // lanes set apart, reserved bits kept clear
        for (int i = 0; i < 4; i++) begin
            lgfs_host_i.wr(5'h05 + 5'(i), {1'b0, 3'(7 - i), 2'(i), 2'b00});
        end
        chk(boost_lanes, {3'd4, 3'd5, 3'd6, 3'd7});
        chk({4'h0, flat_gain_lanes}, 12'h0E4);
        rc(5'h07, 8'h58);
        lgfs_host_i.wr(5'h0A, 8'h5A);
        rc(5'h0A, 8'h5A);
        // every flip setting
        for (int i = 0; i < 4; i++) begin
            lgfs_host_i.wr(5'h09, 8'(i));
            chk({10'h0, aux_pair_swap, main_lane_orientation_swap},
                12'(i));
        end
        // every state code, writes to read-only bytes dropped
        for (int i = 0; i < 8; i++) begin
            lane_zero_power_code <= lgfs_lane_state_t'(i);
            lane_one_power_code <= lgfs_lane_state_t'(7 - i);
            lgfs_host_i.wr(5'h0D, 8'hFF);
            rc(5'h0D, {3'(i), 1'b0, 3'(7 - i), 1'b0});
        end
        lgfs_host_i.wr(5'h02, 8'h00);
        rc(5'h02, 8'h20);
        complete_run();
    end
endmodule
